// *** prs_pkg.sv ***
// shared constants and carrier types for the pressure readout slave
package prs_pkg;

	// bus addressing
	localparam logic [6:0]  PRIMARY_ADDR      = 7'h78;
	localparam logic [6:0]  SECONDARY_ADDR_RST = 7'h00;

	// conversion cycle timing
	localparam int          CLK_HZ            = 100000000;
	localparam int          CYCLE_TIME_NS     = 250000;
	localparam int          CYCLE_CLKS        = (CYCLE_TIME_NS * (CLK_HZ / 1000000)) / 1000;

	// output count encoding for the 3 V variants
	localparam logic [14:0] COUNT_MIN         = 15'h0AAB;
	localparam logic [14:0] COUNT_FULL        = 15'h5FFF;
	localparam logic [14:0] COUNT_ZERO_CENTRE = 15'h3555;
	localparam logic [14:0] FULL_SCALE_SPAN   = 15'h5555;
	localparam logic [14:0] HALF_SPAN         = 15'h2AAA;

	// reset values and the bit count at the acknowledge slot
	localparam logic [14:0] RESULT_RST        = 15'h0AAB;
	localparam logic [3:0]  BIT_CNT_RST       = 4'h0;
	localparam logic [3:0]  BIT_CNT_ACK       = 4'h8;

	// calibration mode: one-sided span or zero-centred span
	typedef enum logic [1:0]
	{
		PRS_MODE_ONE_SIDED = 2'b01,
		PRS_MODE_CENTRED   = 2'b10
	} prs_mode_type;

	// serial engine states
	typedef enum logic [5:0]
	{
		PRS_IDLE     = 6'b000001,
		PRS_ADDR     = 6'b000010,
		PRS_ADDR_ACK = 6'b000100,
		PRS_SEND     = 6'b001000,
		PRS_MACK     = 6'b010000,
		PRS_IGNORE   = 6'b100000
	} prs_state_type;

	// synchronised bus pin levels and their edges
	typedef struct packed
	{
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} prs_bus_type;

endpackage

// *** prs_conv.sv ***
// free-running conversion cycle producing the corrected pressure word
`timescale 1ns/1ns
module prs_conv #(
	parameter int CYCLE_CLKS = prs_pkg::CYCLE_CLKS
)(
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic [11:0]         raw_sample,
	input  wire prs_pkg::prs_mode_type mode,
	output logic      [14:0]         result,
	output logic                     result_strobe
);

	logic [$clog2(CYCLE_CLKS)-1:0] cycle_cnt;
	logic [26:0]                   scaled;
	logic [14:0]                   next_result;

	// cycle divider, one strobe each conversion period
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cycle_cnt     <= '0;
			result_strobe <= 1'b0;
		end
		else if (cycle_cnt == ($clog2(CYCLE_CLKS))'(CYCLE_CLKS - 1))
		begin
			cycle_cnt     <= '0;
			result_strobe <= 1'b1;
		end
		else
		begin
			cycle_cnt     <= cycle_cnt + 1'b1;
			result_strobe <= 1'b0;
		end
	end

	// 12-bit sample scaled onto the full span, offset by the mode's floor
	always_comb
	begin
		scaled = 27'(raw_sample) * 27'(prs_pkg::FULL_SCALE_SPAN);
		if (mode == prs_pkg::PRS_MODE_CENTRED)
			next_result = prs_pkg::COUNT_ZERO_CENTRE - prs_pkg::HALF_SPAN + scaled[26:12];
		else
			next_result = prs_pkg::COUNT_MIN + scaled[26:12];
	end

	// holding register refreshed once per cycle
	always_ff @(posedge clk)
	begin
		if (!resetn)
			result <= prs_pkg::RESULT_RST;
		else if (result_strobe)
			result <= next_result;
	end

endmodule // prs_conv

// *** prs_slave.sv ***
// two-wire read-only slave serving the pressure word
`timescale 1ns/1ns
// Summary of operation
// - new 15-bit result about every 250 us
// - slave only, never drives clock
// - both lines released while idle
// - falling data, clock high: start
// - rising data, clock high: stop
// - repeated starts each served
// - data changes only while clock low
// - eight-bit bytes, most significant first
// - receiver acknowledges on ninth pulse
// - master no-ack: stop sending, release
// - answer primary address 1111000
// - also answer optional secondary address
// - address byte: seven bits plus direction
// - read returns two bytes, 15-bit result
// - one-sided: 2731 to 24575 counts (the scaling here tops out at 24570)
// - centred: zero at 13653 counts
module prs_slave #(
	parameter int CYCLE_CLKS = prs_pkg::CYCLE_CLKS
)(
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe_n,
	output logic                       scl_out,
	output logic                       scl_oe_n,
	input  wire logic [11:0]           raw_sample,
	input  wire prs_pkg::prs_mode_type mode,
	input  wire logic                  secondary_en,
	input  wire logic [6:0]            secondary_addr,
	output logic [14:0]                result,
	output logic                       busy
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [1:0]             scl_sync;
	logic [1:0]             sda_sync;
	logic                   scl_prev;
	logic                   sda_prev;
	prs_pkg::prs_bus_type   bus;
	prs_pkg::prs_state_type state;
	prs_pkg::prs_state_type next_state;
	logic [3:0]             bit_cnt;
	logic [7:0]             addr_shift;
	logic [15:0]            tx_shift;
	logic                   master_ack;
	logic                   addr_match;

	////////////////////////////////////////////////////////////////////////
	// address decode

	// shared by the state logic and the snapshot capture
	function automatic logic addr_hit(
		input logic [6:0] addr,
		input logic       sec_en,
		input logic [6:0] sec_addr
	);
		logic hit;
		hit = (addr == prs_pkg::PRIMARY_ADDR);
		if (sec_en && (addr == sec_addr))
			hit = 1'b1;
		return hit;
	endfunction

	// seven address bits sit above the direction bit
	assign addr_match = addr_hit(addr_shift[7:1], secondary_en, secondary_addr);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge finding

	// two flops on each pin, idle level high so reset leaves no false edge
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
		end
		else
		begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
		end
	end

	// previous synchronised levels, only the second flop is read
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	// bus events; start and stop need the clock high on both samples
	always_comb
	begin
		bus.scl      = scl_sync[1];
		bus.sda      = sda_sync[1];
		bus.scl_rise = scl_sync[1] && !scl_prev;
		bus.scl_fall = !scl_sync[1] && scl_prev;
		bus.start    = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
		bus.stop     = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];
	end

	////////////////////////////////////////////////////////////////////////
	// serial engine

	// state register
	always_ff @(posedge clk)
	begin
		if (!resetn)
			state <= prs_pkg::PRS_IDLE;
		else
			state <= next_state;
	end

	// stop and start win over any slot, so a cut frame always ends cleanly
	always_comb
	begin
		next_state = state;
		if (bus.stop)
			next_state = prs_pkg::PRS_IDLE;
		else if (bus.start)
			next_state = prs_pkg::PRS_ADDR;
		else
		begin
			case (state)
				prs_pkg::PRS_IDLE:
					next_state = prs_pkg::PRS_IDLE;
				prs_pkg::PRS_ADDR:
				begin
					if (bus.scl_fall && (bit_cnt == prs_pkg::BIT_CNT_ACK))
					begin
						if (addr_match)
							next_state = prs_pkg::PRS_ADDR_ACK;
						else
							next_state = prs_pkg::PRS_IGNORE;
					end
				end
				prs_pkg::PRS_ADDR_ACK:
				begin
					// read-only block: a write is acknowledged, then left alone
					if (bus.scl_fall)
					begin
						if (addr_shift[0])
							next_state = prs_pkg::PRS_SEND;
						else
							next_state = prs_pkg::PRS_IGNORE;
					end
				end
				prs_pkg::PRS_SEND:
				begin
					if (bus.scl_fall && (bit_cnt == (prs_pkg::BIT_CNT_ACK - 4'h1)))
						next_state = prs_pkg::PRS_MACK;
				end
				prs_pkg::PRS_MACK:
				begin
					if (bus.scl_fall)
					begin
						if (master_ack)
							next_state = prs_pkg::PRS_SEND;
						else
							next_state = prs_pkg::PRS_IGNORE;
					end
				end
				prs_pkg::PRS_IGNORE:
					next_state = prs_pkg::PRS_IGNORE;
				default:
					next_state = prs_pkg::PRS_IDLE;
			endcase
		end
	end

	// engine is busy whenever it is not idle
	assign busy = (state != prs_pkg::PRS_IDLE);

	////////////////////////////////////////////////////////////////////////
	// bit counting and shifting

	// address bits counted on rises, sent bits on falls
	always_ff @(posedge clk)
	begin
		if (!resetn)
			bit_cnt <= prs_pkg::BIT_CNT_RST;
		else if (bus.start || bus.stop)
			bit_cnt <= prs_pkg::BIT_CNT_RST;
		else if ((state == prs_pkg::PRS_ADDR) && bus.scl_rise)
			bit_cnt <= bit_cnt + 4'h1;
		else if ((state == prs_pkg::PRS_ADDR_ACK) || (state == prs_pkg::PRS_MACK))
			bit_cnt <= prs_pkg::BIT_CNT_RST;
		else if ((state == prs_pkg::PRS_SEND) && bus.scl_fall)
		begin
			if (bit_cnt == (prs_pkg::BIT_CNT_ACK - 4'h1))
				bit_cnt <= prs_pkg::BIT_CNT_RST;
			else
				bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// address byte arrives most significant bit first
	always_ff @(posedge clk)
	begin
		if (!resetn)
			addr_shift <= 8'h00;
		else if (bus.start)
			addr_shift <= 8'h00;
		else if ((state == prs_pkg::PRS_ADDR) && bus.scl_rise)
			addr_shift <= {addr_shift[6:0], bus.sda};
	end

	// snapshot at address match, so a refresh mid-read cannot tear the word
	always_ff @(posedge clk)
	begin
		if (!resetn)
			tx_shift <= 16'h0000;
		else if ((state == prs_pkg::PRS_ADDR) && (next_state == prs_pkg::PRS_ADDR_ACK))
			tx_shift <= {1'b0, result};
		else if ((state == prs_pkg::PRS_SEND) && bus.scl_fall)
			tx_shift <= {tx_shift[14:0], tx_shift[15]};
	end

	// master acknowledge taken while the clock is high
	always_ff @(posedge clk)
	begin
		if (!resetn)
			master_ack <= 1'b0;
		else if ((state == prs_pkg::PRS_MACK) && bus.scl_rise)
			master_ack <= !bus.sda;
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive

	// open drain: the line moves only after a seen clock fall, or is released on a start or stop
	always_ff @(posedge clk)
	begin
		if (!resetn)
			sda_oe_n <= 1'b1;
		else if (bus.stop || bus.start)
			sda_oe_n <= 1'b1;
		else if (bus.scl_fall)
		begin
			case (next_state)
				prs_pkg::PRS_ADDR_ACK:
					sda_oe_n <= 1'b0;
				prs_pkg::PRS_SEND:
				begin
					if (state == prs_pkg::PRS_SEND)
						sda_oe_n <= tx_shift[14];
					else
						sda_oe_n <= tx_shift[15];
				end
				default:
					sda_oe_n <= 1'b1;
			endcase
		end
	end

	// data pin only ever pulls low; the clock pin is never driven
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sda_out  <= 1'b0;
			scl_out  <= 1'b0;
			scl_oe_n <= 1'b1;
		end
		else
		begin
			sda_out  <= 1'b0;
			scl_out  <= 1'b0;
			scl_oe_n <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// conversion cycle

	// sample and mode are on this clock, so no synchroniser is needed
	prs_conv #(
		.CYCLE_CLKS    (CYCLE_CLKS)
	) prs_conv_inst (
		.clk           (clk),
		.resetn        (resetn),
		.raw_sample    (raw_sample),
		.mode          (mode),
		.result        (result),
		.result_strobe ()
	);

endmodule // prs_slave

// *** prs_slave_properties.sv ***
// checker for the two-wire slave ports
`timescale 1ns/1ns
module prs_checker(input wire logic clk,resetn,scl_in,sda_in,sda_out,sda_oe_n,scl_oe_n,busy,
	input wire logic [14:0] result);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
chk_clock_released: assert property (scl_oe_n) else $error("scl driven");
chk_drive_busy: assert property (!sda_oe_n |-> busy) else $error("sda driven idle");
chk_idle_released: assert property (!busy |-> sda_oe_n) else $error("idle not free");
chk_start_seen: assert property ($fell(sda_in) && scl_in |-> ##[1:8] busy) else $error("start");
chk_stop_seen: assert property ($rose(sda_in) && scl_in |-> ##[1:8] !busy) else $error("stop");
chk_data_clk_low: assert property ($changed(sda_oe_n) |-> !scl_in) else $error("sda moved");
chk_pull_low: assert property (!sda_oe_n |-> !sda_out) else $error("sda high");
chk_result_range: assert property (result>=prs_pkg::COUNT_MIN && result<=prs_pkg::COUNT_FULL)
	else $error("range");
endmodule // prs_checker
bind prs_slave prs_checker prs_checker_inst(.*);

// *** prs_master.sv ***
// two-wire bus master model
`timescale 1ns/1ns
module prs_master(input wire logic clk,sda_in,output logic scl=1,sda=1);
// quarter bit; the bench link runs far above the field rate to keep runs short
task q; repeat(3) @(posedge clk); endtask
task start; sda<=1; q; scl<=1; q; sda<=0; q; scl<=0; q; endtask
task stop; sda<=0; q; scl<=1; q; sda<=1; q; endtask
// eight data bits then the acknowledge slot
task xfer(input logic [8:0] d,output logic [8:0] r);
	for(int i=8;i>=0;i--) begin sda<=d[i]; q; scl<=1; q; r[i]=sda_in; q; scl<=0; q; end
endtask
endmodule // prs_master

// *** prs_slave_bench.sv ***
// bench for the pressure readout slave
`timescale 1ns/1ns
module prs_slave_bench;
logic clk=0,resetn=0,sec_en=0,oe_n,so,coe_n,co,busy,ms,mc;
logic [11:0] raw=12'h000;
logic [6:0] sec=7'h22;
prs_pkg::prs_mode_type mode=prs_pkg::PRS_MODE_ONE_SIDED;
logic [14:0] res;
logic [8:0] r,s;
wire sda=ms&(oe_n|so);
wire scl=mc&(coe_n|co);
int failures=0,n_compared=0,cyc=0;
prs_slave #(.CYCLE_CLKS(50)) prs_slave_inst(.clk,.resetn,.scl_in(scl),.sda_in(sda),.sda_out(so),
	.sda_oe_n(oe_n),.scl_out(co),.scl_oe_n(coe_n),.raw_sample(raw),.mode,.secondary_en(sec_en),
	.secondary_addr(sec),.result(res),.busy);
prs_master prs_master_inst(.clk,.sda_in(sda),.scl(mc),.sda(ms));
initial forever #5 clk=~clk;
always @(posedge clk) if(++cyc==30000) begin failures++; test_done; end
task chk(string n,logic [15:0] e,v);
	n_compared++;
	if(e!==v) begin failures++; $display("wrong value %s exp %h seen %h",n,e,v); end
endtask
task test_done; if(failures==0&&n_compared>0) $display("TB: PASS"); else $display("TB: FAIL"); $finish; endtask
// address, then two bytes, master ack then no-ack
task rd(logic [6:0] a,logic [15:0] e);
	prs_master_inst.xfer({a,2'b11},r);
	chk("ack",0,r[0]);
	prs_master_inst.xfer(9'h1FE,r); prs_master_inst.xfer(9'h1FF,s);
	chk("word",e,{r[8:1],s[8:1]});
endtask
task t_primary;
	chk("result",{1'b0,prs_pkg::COUNT_MIN},{1'b0,res});
	chk("scl release",1,coe_n);
	prs_master_inst.start; rd(7'h78,{1'b0,prs_pkg::COUNT_MIN}); prs_master_inst.stop;
endtask
task t_nomatch;
	prs_master_inst.start; prs_master_inst.xfer(9'h0AB,r);
	chk("nak",1,r[0]);
	prs_master_inst.stop;
endtask
// write to the primary address: address taken, data byte refused
task t_write;
	prs_master_inst.start; prs_master_inst.xfer({7'h78,2'b01},r);
	chk("write ack",0,r[0]);
	prs_master_inst.xfer(9'h1A5,r);
	chk("write data nak",1,r[0]);
	prs_master_inst.stop;
endtask
// secondary address, centred mode, chained by a repeated start
task t_chain;
	sec_en<=1; mode<=prs_pkg::PRS_MODE_CENTRED; raw<=12'h800; repeat(120) @(posedge clk);
	chk("centred result",{1'b0,prs_pkg::COUNT_ZERO_CENTRE},{1'b0,res});
	prs_master_inst.start; rd(7'h22,{1'b0,prs_pkg::COUNT_ZERO_CENTRE});
	prs_master_inst.start; rd(7'h78,{1'b0,prs_pkg::COUNT_ZERO_CENTRE});
	prs_master_inst.stop; repeat(9) @(posedge clk); chk("busy",0,busy);
endtask
initial begin repeat(16) @(posedge clk); resetn<=1; repeat(120) @(posedge clk);
	t_primary; t_nomatch; t_write; t_chain; test_done; end
endmodule // prs_slave_bench
